// File: hw/mtp_protect.sv
// Motor thermal protection: thermal compare, relay and thermistor faults
// Operation
// - Second select makes second settings valid
// - Second select on dedicated terminal; code 3 adds it on other terminals
// - Prealarm at 85 percent of active rating
// - Trip and stop output at 100 percent
// - Prealarm alone never stops the output
// - Prealarm drives outputs selected 8 or 108
// - External relay active stops output, flags fault
// - External relay taken from inputs with code 7
// - Thermistor needs code 63 and switch set
// - Overheat held over 10 s trips
// - Classify thermistor normal, boundary, overheat
// - Switch set without code: aux function off
// - Code set, switch ordinary: permanent overheat
// - Applied motor resets 0, accepts listed codes
// - Second motor resets 9999, which disables it
// - Vector control also selects motor constants
// - Second select uses second rated current
// - Active rating zero disables motor protection only
// - Reset clears thermal state and faults
`timescale 1ns/1ps
module mtp_protect
  import mtp_pkg::*;
#(
  parameter int NUM_IN = 12,
  parameter int NUM_OUT = 7,
  parameter int SEC_TERM = 0,
  parameter int PTC_HOLD = mtp_pkg::PTC_HOLD_CYCLES
) (
  // Clock and reset
  input wire logic mclk,
  input wire logic rst_b,
  // Input terminal pins and function selection writes
  input wire logic [NUM_IN-1:0] inTermPin,
  input wire logic inSelWr,
  input wire logic [3:0] inSelIdx,
  input wire logic [mtp_pkg::SEL_W-1:0] inSelData,
  // Auxiliary terminal and thermistor
  input wire logic auxTermPin,
  input wire logic auxSelWr,
  input wire logic [mtp_pkg::SEL_W-1:0] auxSelData,
  input wire logic ptcModeSwitch,
  input wire logic [15:0] ptcOhms,
  // Output terminal function selection
  input wire logic [NUM_OUT*mtp_pkg::SEL_W-1:0] outSel,
  // Rated current settings
  input wire logic [mtp_pkg::RATED_W-1:0] firstRated,
  input wire logic [mtp_pkg::RATED_W-1:0] secondRated,
  input wire logic [mtp_pkg::RATED_W-1:0] transistorLimit,
  // Heat sources
  input wire logic [15:0] motorHeat,
  input wire logic [15:0] motorCool,
  input wire logic [15:0] transHeat,
  input wire logic [15:0] transCool,
  // Applied motor settings
  input wire logic motorWr,
  input wire logic [mtp_pkg::MOTOR_W-1:0] motorData,
  input wire logic motor2Wr,
  input wire logic [mtp_pkg::MOTOR_W-1:0] motor2Data,
  input wire logic vectorCtrl,
  // Status
  output logic secondFuncActive,
  output logic [mtp_pkg::RATED_W-1:0] activeRated,
  output logic thermalPrealarm,
  output logic motorThermalTrip,
  output logic transistorThermalTrip,
  output logic externalThermalFault,
  output logic thermistorFault,
  output logic outputStop,
  output logic [1:0] ptcClass,
  output logic auxFuncActive,
  output logic [mtp_pkg::SEL_W-1:0] auxFuncCode,
  output logic [NUM_OUT-1:0] outTerm,
  // Applied motor status
  output logic [mtp_pkg::MOTOR_W-1:0] appliedMotor,
  output logic [mtp_pkg::MOTOR_W-1:0] secondAppliedMotor,
  output logic [mtp_pkg::MOTOR_W-1:0] thermalCurveSel,
  output logic [mtp_pkg::MOTOR_W-1:0] motorConstSel,
  output logic motorConstValid
);
  import mtp_pkg::*;

  // ==========================================================
  // Pin synchronisers
  logic [NUM_IN-1:0] inMeta_ff, inSync_ff;
  logic auxMeta_ff, auxSync_ff;
  logic swMeta_ff, swSync_ff;

  // Two flops per pin; only the second stage is read
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      inMeta_ff <= '0;
      inSync_ff <= '0;
      auxMeta_ff <= 1'b0;
      auxSync_ff <= 1'b0;
      swMeta_ff <= 1'b0;
      swSync_ff <= 1'b0;
    end else begin
      inMeta_ff <= inTermPin;
      inSync_ff <= inMeta_ff;
      auxMeta_ff <= auxTermPin;
      auxSync_ff <= auxMeta_ff;
      swMeta_ff <= ptcModeSwitch;
      swSync_ff <= swMeta_ff;
    end
  end

  // ==========================================================
  // Terminal function selections
  logic [SEL_W-1:0] inSel_ff [NUM_IN];
  logic [SEL_W-1:0] nxt_inSel [NUM_IN];
  logic [SEL_W-1:0] auxSel_ff, nxt_auxSel;

  // Writes land on the addressed terminal; out-of-range index is ignored
  always_comb begin
    for (int i = 0; i < NUM_IN; i++) begin
      nxt_inSel[i] = inSel_ff[i];
      if (inSelWr && (int'(inSelIdx) == i)) begin
        nxt_inSel[i] = inSelData;
      end
    end
    nxt_auxSel = auxSelWr ? auxSelData : auxSel_ff;
  end

  // Second select starts on its dedicated terminal
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      for (int i = 0; i < NUM_IN; i++) begin
        inSel_ff[i] <= (i == SEC_TERM) ? FUNC_SECOND : FUNC_NONE;
      end
      auxSel_ff <= FUNC_AUX_DEF;
    end else begin
      for (int i = 0; i < NUM_IN; i++) begin
        inSel_ff[i] <= nxt_inSel[i];
      end
      auxSel_ff <= nxt_auxSel;
    end
  end

  // ==========================================================
  // Input function decode
  logic secLevel;              // Second select from any terminal holding its code
  logic relayLevel;            // External relay from any terminal holding its code
  logic ptcCoded, ptcMode, ptcEnabled, ptcStuck;

  // Several terminals with the same code are OR-ed together
  always_comb begin
    secLevel = 1'b0;
    relayLevel = 1'b0;
    for (int i = 0; i < NUM_IN; i++) begin
      if (inSel_ff[i] == FUNC_SECOND) begin
        secLevel = secLevel | inSync_ff[i];
      end
      if (inSel_ff[i] == FUNC_RELAY) begin
        relayLevel = relayLevel | inSync_ff[i];
      end
    end
    ptcCoded = (auxSel_ff == FUNC_PTC);
    ptcMode = swSync_ff;
    ptcEnabled = ptcCoded && ptcMode;
    ptcStuck = ptcCoded && !ptcMode;
  end

  // ==========================================================
  // Applied motor settings
  logic [MOTOR_W-1:0] motor_ff, nxt_motor;
  logic [MOTOR_W-1:0] motor2_ff, nxt_motor2;

  // Codes outside the list, other than 9999 for the second motor, are dropped and the old value stays
  always_comb begin
    nxt_motor = motor_ff;
    nxt_motor2 = motor2_ff;
    if (motorWr && mtp_motor_code_ok(motorData)) begin
      nxt_motor = motorData;
    end
    if (motor2Wr && (mtp_motor_code_ok(motor2Data) || (motor2Data == MOTOR_OFF))) begin
      nxt_motor2 = motor2Data;
    end
  end

  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      motor_ff <= MOTOR_RST;
      motor2_ff <= MOTOR_OFF;
    end else begin
      motor_ff <= nxt_motor;
      motor2_ff <= nxt_motor2;
    end
  end

  // ==========================================================
  // Active setting selection
  logic useSecondRated;
  logic useSecondMotor;
  logic [RATED_W-1:0] ratedSel;
  logic [MOTOR_W-1:0] curveSel;

  // A second setting of 9999 leaves the first in force even with the select on
  always_comb begin
    useSecondRated = secLevel && (secondRated != RATED_OFF);
    useSecondMotor = secLevel && (motor2_ff != MOTOR_OFF);
    ratedSel = useSecondRated ? secondRated : firstRated;
    curveSel = useSecondMotor ? motor2_ff : motor_ff;
  end

  // ==========================================================
  // Thermal accumulators
  logic motorEnable;
  logic motorPre, motorHit, transPre, transHit;

  // A zero rating turns motor protection off; the transistor path stays on
  assign motorEnable = (ratedSel != RATED_ZERO);

  mtp_accum #(.W(ACC_W)) u_motor_acc (
    .mclk(mclk),
    .rst_b(rst_b),
    .enable(motorEnable),
    .heatIn(motorHeat),
    .coolIn(motorCool),
    .level(ratedSel),
    .prealarm(motorPre),
    .reached(motorHit)
  );

  mtp_accum #(.W(ACC_W)) u_trans_acc (
    .mclk(mclk),
    .rst_b(rst_b),
    .enable(1'b1),
    .heatIn(transHeat),
    .coolIn(transCool),
    .level(transistorLimit),
    .prealarm(transPre),
    .reached(transHit)
  );

  // ==========================================================
  // Thermistor classification and persistence
  mtp_ptc_e ptcCls;
  logic ptcHot;
  logic [31:0] ptcCnt_ff, nxt_ptcCnt;

  // Boundary band never counts in thermistor mode; only a true overheat reading does
  always_comb begin
    if (ptcOhms < PTC_NORMAL_MAX_OHM) begin
      ptcCls = PTC_NORMAL;
    end else if (ptcOhms < PTC_OVERHEAT_OHM) begin
      ptcCls = PTC_BOUNDARY;
    end else begin
      ptcCls = PTC_OVERHEAT;
    end
    ptcHot = ptcStuck || (ptcEnabled && (ptcCls == PTC_OVERHEAT));
    if (!ptcHot) begin
      nxt_ptcCnt = '0;          // Any break restarts the persistence window
    end else if (ptcCnt_ff <= 32'(PTC_HOLD)) begin
      nxt_ptcCnt = ptcCnt_ff + 32'h00000001;
    end else begin
      nxt_ptcCnt = ptcCnt_ff;   // Holds once past the limit
    end
  end

  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      ptcCnt_ff <= '0;
    end else begin
      ptcCnt_ff <= nxt_ptcCnt;
    end
  end

  // ==========================================================
  // Fault latches and status
  logic thm_ff, nxt_thm;
  logic tht_ff, nxt_tht;
  logic oht_ff, nxt_oht;
  logic ptcF_ff, nxt_ptcF;
  logic pre_ff, nxt_pre;

  // Faults hold until reset so the stop cannot release on its own
  always_comb begin
    nxt_thm = thm_ff || (motorEnable && motorHit);
    nxt_tht = tht_ff || transHit;
    nxt_oht = oht_ff || relayLevel;
    nxt_ptcF = ptcF_ff || (ptcCnt_ff > 32'(PTC_HOLD));
    nxt_pre = motorPre || transPre;
  end

  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      thm_ff <= 1'b0;
      tht_ff <= 1'b0;
      oht_ff <= 1'b0;
      ptcF_ff <= 1'b0;
      pre_ff <= 1'b0;
    end else begin
      thm_ff <= nxt_thm;
      tht_ff <= nxt_tht;
      oht_ff <= nxt_oht;
      ptcF_ff <= nxt_ptcF;
      pre_ff <= nxt_pre;
    end
  end

  // ==========================================================
  // Outputs
  logic [NUM_OUT-1:0] nxt_out, out_ff;

  // Prealarm is absent from the stop term on purpose
  assign outputStop = thm_ff || tht_ff || oht_ff || ptcF_ff;

  // Output terminals carry the prealarm in either polarity
  always_comb begin
    for (int j = 0; j < NUM_OUT; j++) begin
      case (outSel[j*SEL_W +: SEL_W])
        OUT_PRE_POS: nxt_out[j] = pre_ff;
        OUT_PRE_NEG: nxt_out[j] = !pre_ff;
        default: nxt_out[j] = 1'b0;
      endcase
    end
  end

  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      out_ff <= '0;
    end else begin
      out_ff <= nxt_out;
    end
  end

  assign outTerm = out_ff;
  assign secondFuncActive = secLevel;
  assign activeRated = ratedSel;
  assign thermalPrealarm = pre_ff;
  assign motorThermalTrip = thm_ff;
  assign transistorThermalTrip = tht_ff;
  assign externalThermalFault = oht_ff;
  assign thermistorFault = ptcF_ff;
  assign ptcClass = (ptcCls == PTC_OVERHEAT) ? 2'h2 : ((ptcCls == PTC_BOUNDARY) ? 2'h1 : 2'h0);
  // In thermistor mode the ordinary aux function is forced off
  assign auxFuncActive = ptcMode ? 1'b0 : auxSync_ff;
  assign auxFuncCode = auxSel_ff;
  assign appliedMotor = motor_ff;
  assign secondAppliedMotor = motor2_ff;
  assign thermalCurveSel = curveSel;
  // Motor constants follow the same code only under vector control
  assign motorConstSel = vectorCtrl ? curveSel : MOTOR_RST;
  assign motorConstValid = vectorCtrl;
endmodule

// File: hw/mtp_pkg.sv
// Shared constants and helpers for the motor thermal protection block
package mtp_pkg;

  // ==========================================================
  // Terminal function codes
  localparam logic [7:0] FUNC_SECOND = 8'h03;   // Second function select
  localparam logic [7:0] FUNC_RELAY = 8'h07;    // External thermal relay
  localparam logic [7:0] FUNC_PTC = 8'h3f;      // Thermistor on auxiliary terminal
  localparam logic [7:0] FUNC_NONE = 8'hff;     // No function assigned
  localparam logic [7:0] FUNC_AUX_DEF = 8'h04;  // Ordinary auxiliary function
  localparam logic [7:0] OUT_PRE_POS = 8'h08;   // Prealarm, active high
  localparam logic [7:0] OUT_PRE_NEG = 8'h6c;   // Prealarm, active low

  // ==========================================================
  // Setting widths, reset values and the disable marker
  localparam int SEL_W = 8;
  localparam int MOTOR_W = 14;
  localparam int RATED_W = 16;
  localparam logic [MOTOR_W-1:0] MOTOR_RST = 14'h0000;
  localparam logic [MOTOR_W-1:0] MOTOR_OFF = 14'h270f;  // 9999 disables
  localparam logic [RATED_W-1:0] RATED_OFF = 16'h270f;  // 9999 invalid
  localparam logic [RATED_W-1:0] RATED_ZERO = 16'h0000;

  // ==========================================================
  // Thermal accumulator thresholds
  localparam int ACC_FRAC = 16;                 // Fraction bits under the rating
  localparam int ACC_W = RATED_W + ACC_FRAC;
  localparam int PRE_PCT = 85;
  localparam int TRIP_PCT = 100;

  // ==========================================================
  // Thermistor classification and persistence timing
  localparam logic [15:0] PTC_NORMAL_MAX_OHM = 16'h01f4;  // 500 ohm
  localparam logic [15:0] PTC_OVERHEAT_OHM = 16'h0fa0;    // 4000 ohm
  typedef enum {PTC_NORMAL, PTC_BOUNDARY, PTC_OVERHEAT} mtp_ptc_e;
  localparam int PTC_HOLD_S = 10;
  localparam int MCLK_HZ = 25000000;
  localparam int PTC_HOLD_CYCLES = PTC_HOLD_S * MCLK_HZ;

  // ==========================================================
  // Accepted applied-motor codes
  function automatic logic mtp_motor_code_ok(input logic [MOTOR_W-1:0] code);
    case (code)
      14'd0, 14'd1, 14'd2, 14'd3, 14'd4, 14'd5, 14'd6, 14'd7, 14'd8,
      14'd13, 14'd14, 14'd15, 14'd16, 14'd17, 14'd18,
      14'd20, 14'd23, 14'd24, 14'd30, 14'd33, 14'd34,
      14'd40, 14'd43, 14'd44, 14'd50, 14'd53, 14'd54: mtp_motor_code_ok = 1'b1;
      default: mtp_motor_code_ok = 1'b0;
    endcase
  endfunction

endpackage

// File: hw/mtp_accum.sv
// Saturating thermal accumulator with prealarm and trip compares
`timescale 1ns/1ps
module mtp_accum
  import mtp_pkg::*;
#(
  parameter int W = mtp_pkg::ACC_W
) (
  // Clock and reset
  input wire logic mclk,
  input wire logic rst_b,
  // Heating and cooling
  input wire logic enable,
  input wire logic [15:0] heatIn,
  input wire logic [15:0] coolIn,
  input wire logic [mtp_pkg::RATED_W-1:0] level,
  // Results
  output logic prealarm,
  output logic reached
);
  import mtp_pkg::*;

  // ==========================================================
  // State
  logic [W-1:0] acc_ff;        // Accumulated heat
  logic [W-1:0] nxt_acc;
  logic pre_ff, nxt_pre;
  logic hit_ff, nxt_hit;
  logic [W:0] sum;             // One spare bit to see overflow
  logic [W-1:0] full;          // Trip level in accumulator units
  logic [W+7:0] accScaled;
  logic [W+7:0] preScaled;

  // Heat only while protection is on; cooling always runs
  always_comb begin
    sum = {1'b0, acc_ff} + {{(W-15){1'b0}}, (enable ? heatIn : 16'h0000)};
    full = {level, {ACC_FRAC{1'b0}}};
    if (sum[W]) begin
      nxt_acc = {W{1'b1}};      // Saturate high
    end else if (sum[W-1:0] > {{(W-16){1'b0}}, coolIn}) begin
      nxt_acc = sum[W-1:0] - {{(W-16){1'b0}}, coolIn};
    end else begin
      nxt_acc = '0;             // Saturate at empty
    end
    accScaled = {8'h00, acc_ff} * (W+8)'(TRIP_PCT);
    preScaled = {8'h00, full} * (W+8)'(PRE_PCT);
    nxt_pre = enable && (accScaled >= preScaled);
    nxt_hit = enable && (acc_ff >= full);
  end

  // Register state; reset clears the heat memory
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      acc_ff <= '0;
      pre_ff <= 1'b0;
      hit_ff <= 1'b0;
    end else begin
      acc_ff <= nxt_acc;
      pre_ff <= nxt_pre;
      hit_ff <= nxt_hit;
    end
  end

  assign prealarm = pre_ff;
  assign reached = hit_ff;
endmodule

// File: test/mtp_protect_sva.sv
// Concurrent checks on the motor thermal protection ports
`timescale 1ns/1ps
module mtp_protect_sva #(
  parameter int NUM_IN = 12,
  parameter int NUM_OUT = 7,
  parameter int PTC_HOLD = 20
) (
  // Clock, reset and watched inputs
  input wire logic mclk,
  input wire logic rst_b,
  input wire logic [NUM_IN-1:0] inTermPin,
  input wire logic ptcModeSwitch,
  input wire logic [15:0] ptcOhms,
  input wire logic [NUM_OUT*mtp_pkg::SEL_W-1:0] outSel,
  input wire logic [mtp_pkg::RATED_W-1:0] firstRated,
  input wire logic [mtp_pkg::RATED_W-1:0] secondRated,
  input wire logic motorWr,
  input wire logic [mtp_pkg::MOTOR_W-1:0] motorData,
  input wire logic vectorCtrl,
  // Watched outputs
  input wire logic secondFuncActive,
  input wire logic [mtp_pkg::RATED_W-1:0] activeRated,
  input wire logic thermalPrealarm,
  input wire logic motorThermalTrip,
  input wire logic transistorThermalTrip,
  input wire logic externalThermalFault,
  input wire logic thermistorFault,
  input wire logic outputStop,
  input wire logic [1:0] ptcClass,
  input wire logic auxFuncActive,
  input wire logic [NUM_OUT-1:0] outTerm,
  input wire logic [mtp_pkg::MOTOR_W-1:0] appliedMotor,
  input wire logic [mtp_pkg::MOTOR_W-1:0] thermalCurveSel,
  input wire logic [mtp_pkg::MOTOR_W-1:0] motorConstSel
);
  import mtp_pkg::*;
  default clocking @(posedge mclk); endclocking
  default disable iff (!rst_b);
  // ==========================================================
  // Helper state
  logic [3:0] faults; // All sticky fault flags together
  logic [7:0] hotCnt_ff; // Cycles in a row with the switch off or a reading at or above 4000 ohm
  logic [7:0] nxt_hotCnt;
  assign faults = {motorThermalTrip, transistorThermalTrip, externalThermalFault, thermistorFault};
  // Saturates so a long hot spell never wraps
  always_comb begin
    nxt_hotCnt = hotCnt_ff;
    if (ptcModeSwitch && ptcOhms < PTC_OVERHEAT_OHM) begin
      nxt_hotCnt = 8'h00;
    end else if (hotCnt_ff != 8'hff) begin
      nxt_hotCnt = hotCnt_ff + 8'h01;
    end
  end
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      hotCnt_ff <= 8'h00;
    end else begin
      hotCnt_ff <= nxt_hotCnt;
    end
  end
  // ==========================================================
  // Sequences
  sequence s_switch_held;
    ptcModeSwitch [*3];
  endsequence
  sequence s_relay_rise;
    $rose(externalThermalFault);
  endsequence
  // ==========================================================
  // Assertions
  a_stop_from_faults:
    assert property (outputStop == (|faults)) else $error("stop differs from faults");
  a_faults_sticky:
    assert property (1'b1 |=> (faults & $past(faults)) == $past(faults))
    else $error("fault cleared without reset");
  a_ptc_class_map:
    assert property (ptcClass == ((ptcOhms >= PTC_OVERHEAT_OHM) ? 2'h2 :
      ((ptcOhms >= PTC_NORMAL_MAX_OHM) ? 2'h1 : 2'h0))) else $error("bad thermistor class");
  a_aux_forced_off:
    assert property (s_switch_held |-> !auxFuncActive) else $error("aux active in thermistor mode");
  a_relay_fault_cause:
    assert property (s_relay_rise |-> $past(|inTermPin, 3)) else $error("relay fault without pin");
  a_ptc_hold_time:
    assert property ($rose(thermistorFault) |-> hotCnt_ff >= PTC_HOLD)
    else $error("thermistor fault too early");
  a_trip_after_pre:
    assert property ($rose(motorThermalTrip) |-> thermalPrealarm) else $error("trip before prealarm");
  a_rated_in_use:
    assert property (activeRated == ((secondFuncActive && secondRated != RATED_OFF) ?
      secondRated : firstRated)) else $error("wrong rating in use");
  a_const_follows:
    assert property (motorConstSel == (vectorCtrl ? thermalCurveSel : 14'h0000))
    else $error("motor constants wrong");
  a_motor_accept:
    assert property (motorWr && (motorData <= 14'h0008 || (motorData >= 14'h000d &&
      motorData <= 14'h0012)) |=> appliedMotor == $past(motorData)) else $error("code lost");
  a_motor_refuse:
    assert property (motorWr && motorData == 14'h0009 |=> $stable(appliedMotor))
    else $error("bad code taken");
  a_out_positive:
    assert property (outSel[7:0] == OUT_PRE_POS && $stable(outSel) && $stable(thermalPrealarm)
      |-> outTerm[0] == thermalPrealarm) else $error("positive terminal wrong");
  a_out_negative:
    assert property (outSel[15:8] == OUT_PRE_NEG && $stable(outSel) && $past(rst_b) &&
      $stable(thermalPrealarm) |-> outTerm[1] == !thermalPrealarm) else $error("negative wrong");
endmodule
bind mtp_protect mtp_protect_sva #(.NUM_IN(NUM_IN), .NUM_OUT(NUM_OUT), .PTC_HOLD(PTC_HOLD)) u_sva (
  .mclk, .rst_b, .inTermPin, .ptcModeSwitch, .ptcOhms, .outSel, .firstRated, .secondRated,
  .motorWr, .motorData, .vectorCtrl, .secondFuncActive, .activeRated, .thermalPrealarm,
  .motorThermalTrip, .transistorThermalTrip, .externalThermalFault, .thermistorFault,
  .outputStop, .ptcClass, .auxFuncActive, .outTerm, .appliedMotor, .thermalCurveSel,
  .motorConstSel
);

// File: test/mtp_sensor_model.sv
// Behavioural model of the motor thermistor and the external thermal relay
`timescale 1ns/1ps
module mtp_sensor_model (
  // Commanded motor state: 0 cool, 1 at 500 ohm, 2 just below 4k, 3 hot
  input wire logic [1:0] heatLevel,
  input wire logic relayOpen,
  // Sensor outputs
  output logic [15:0] ptcOhms,
  output logic relayPin
);
  // Follows the command at once, so no edge race; steps sit on the class edges
  always_comb begin
    case (heatLevel)
      2'h0: ptcOhms = 16'h012c;
      2'h1: ptcOhms = 16'h01f4;
      2'h2: ptcOhms = 16'h0f9f;
      default: ptcOhms = 16'h0fa0;
    endcase
  end
  assign relayPin = relayOpen;
endmodule

// File: test/mtp_protect_tb.sv
// Self-checking testbench for the motor thermal protection block
`timescale 1ns/1ps
module mtp_protect_tb;
  import mtp_pkg::*;
  localparam int HOLD = 20; // Short persistence so the run stays brief
  logic mclk, rst_b, inSelWr, auxSelWr, auxTermPin, ptcModeSwitch, motorWr, motor2Wr;
  logic vectorCtrl, relayOpen, relayPin, secondFuncActive, thermalPrealarm, outputStop;
  logic motorThermalTrip, transistorThermalTrip, externalThermalFault, thermistorFault;
  logic auxFuncActive, motorConstValid;
  logic [4:0] flags;
  logic [11:0] pins, inTermPin;
  logic [3:0] inSelIdx;
  logic [7:0] inSelData, auxSelData, auxFuncCode;
  logic [15:0] ptcOhms, firstRated, secondRated, transistorLimit, motorHeat, transHeat;
  logic [15:0] activeRated;
  logic [55:0] outSel;
  logic [13:0] motorData, motor2Data, appliedMotor, secondAppliedMotor, thermalCurveSel;
  logic [13:0] motorConstSel;
  logic [1:0] heatLevel, ptcClass;
  logic [6:0] outTerm;
  int numErrors, checkCount, n, m;
  logic [13:0] codes [6] = '{14'h000d, 14'h0009, 14'h0012, 14'h0013, 14'h0008, 14'h0014};
  logic [13:0] kept [6] = '{14'h000d, 14'h000d, 14'h0012, 14'h0012, 14'h0008, 14'h0014};
  // Relay contact from the model lands on terminal 3
  assign inTermPin = pins | {8'h00, relayPin, 3'h0};
  assign outSel = {{5{FUNC_NONE}}, OUT_PRE_NEG, OUT_PRE_POS};
  assign flags = {transistorThermalTrip, thermistorFault, externalThermalFault,
    motorThermalTrip, thermalPrealarm};
  mtp_protect #(.PTC_HOLD(HOLD)) DUT (.mclk, .rst_b, .inTermPin, .inSelWr, .inSelIdx,
    .inSelData, .auxTermPin, .auxSelWr, .auxSelData, .ptcModeSwitch, .ptcOhms, .outSel,
    .firstRated, .secondRated, .transistorLimit, .motorHeat, .motorCool(16'h0000), .transHeat,
    .transCool(16'h0000), .motorWr, .motorData, .motor2Wr, .motor2Data, .vectorCtrl,
    .secondFuncActive, .activeRated, .thermalPrealarm, .motorThermalTrip,
    .transistorThermalTrip, .externalThermalFault, .thermistorFault, .outputStop, .ptcClass,
    .auxFuncActive, .auxFuncCode, .outTerm, .appliedMotor, .secondAppliedMotor,
    .thermalCurveSel, .motorConstSel, .motorConstValid);
  mtp_sensor_model partner (.heatLevel, .relayOpen, .ptcOhms, .relayPin);
  initial begin
    mclk = 1'b0;
    forever #20 mclk = ~mclk;
  end
  // ==========================================================
  // Access tasks; every input moves on the falling edge
  task automatic step(input int k);
    repeat (k) @(negedge mclk);
  endtask
  task automatic check(input logic [15:0] seen, input logic [15:0] want);
    checkCount++;
    if (seen !== want) begin
      numErrors++;
      $display("FAIL t=%0t saw %h wanted %h", $time, seen, want);
    end
  endtask
  task automatic doReset();
    rst_b = 1'b0;
    step(4);
    rst_b = 1'b1;
  endtask
  // Strobe drops for a cycle between writes
  task automatic wrSel(input logic aux, input logic [3:0] idx, input logic [7:0] code);
    {inSelIdx, inSelData, auxSelData} = {idx, code, code};
    {inSelWr, auxSelWr} = {!aux, aux};
    step(1);
    {inSelWr, auxSelWr} = 2'h0;
    step(1);
  endtask
  task automatic wrMotor(input logic second, input logic [13:0] code);
    {motorData, motor2Data} = {code, code};
    {motorWr, motor2Wr} = {!second, second};
    step(1);
    {motorWr, motor2Wr} = 2'h0;
    step(1);
  endtask
  // Bounded wait; running out ends the run as a failure
  task automatic waitFlag(input int which, input int lim, output int k);
    k = 0;
    while (flags[which] !== 1'b1 && k < lim) begin
      step(1);
      k++;
    end
    if (k == lim) begin
      numErrors++;
      $display("FAIL t=%0t wait ran out", $time);
      endOfTest();
    end
  endtask
  task automatic endOfTest();
    $display("Checks %0d errors %0d", checkCount, numErrors);
    if (numErrors == 0 && checkCount > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask
  // ==========================================================
  // Scenarios
  initial begin
    {inSelWr, auxSelWr, auxTermPin, ptcModeSwitch, motorWr, motor2Wr, vectorCtrl} = 7'h00;
    {relayOpen, pins, inSelIdx, inSelData, auxSelData, heatLevel} = 35'h0;
    {firstRated, secondRated, motorHeat, transHeat, transistorLimit} = {64'h0, 16'hffff};
    {motorData, motor2Data} = 28'h0;
    numErrors = 0;
    checkCount = 0;
    doReset();
    check(appliedMotor, 16'h0000);
    check(secondAppliedMotor, 16'h270f);
    check(auxFuncCode, 16'h0004);
    for (int i = 0; i < 6; i++) begin
      wrMotor(1'b0, codes[i]);
      check(appliedMotor, kept[i]);
    end
    vectorCtrl = 1'b1;
    step(1);
    check(motorConstSel, 16'h0014);
    check(motorConstValid, 1'b1);
    vectorCtrl = 1'b0;
    step(1);
    check(motorConstSel, 16'h0000);
    check(motorConstValid, 1'b0);
    // Second select on its own terminal, then also coded on terminal 5
    {firstRated, secondRated} = {16'h0001, 16'h0032};
    wrMotor(1'b1, 14'h0005);
    pins[0] = 1'b1;
    step(4);
    check(secondFuncActive, 1'b1);
    check(activeRated, 16'h0032);
    check(thermalCurveSel, 16'h0005);
    pins[0] = 1'b0;
    wrSel(1'b0, 4'h5, FUNC_SECOND);
    pins[5] = 1'b1;
    step(4);
    check(secondFuncActive, 1'b1);
    secondRated = RATED_OFF;
    step(1);
    check(activeRated, 16'h0001);
    pins[5] = 1'b0;
    // Thermal ramp: 1000 per cycle against a rating of one unit
    doReset();
    motorHeat = 16'h03e8;
    waitFlag(0, 100, n);
    check(n >= 56 && n <= 60, 1'b1);
    step(2);
    check(outputStop, 1'b0);
    check(outTerm[1:0], 2'h1);
    waitFlag(1, 30, m);
    check(n + m + 2 >= 66 && n + m + 2 <= 70, 1'b1);
    check(outputStop, 1'b1);
    // Zero rating: motor protection off, transistor path still trips
    motorHeat = 16'h0000;
    doReset();
    {firstRated, transistorLimit, motorHeat, transHeat} = {16'h0, 16'h1, 16'h4000, 16'h4000};
    waitFlag(4, 50, n);
    check(motorThermalTrip, 1'b0);
    {motorHeat, transHeat, transistorLimit} = {32'h0, 16'hffff};
    // External relay: only a terminal coded 7 counts
    doReset();
    pins[4] = 1'b1;
    step(10);
    check(externalThermalFault, 1'b0);
    pins[4] = 1'b0;
    wrSel(1'b0, 4'h3, FUNC_RELAY);
    relayOpen = 1'b1;
    waitFlag(2, 8, n);
    check(outputStop, 1'b1);
    relayOpen = 1'b0;
    // Thermistor classes, then persistence
    doReset();
    for (int i = 0; i < 4; i++) begin
      heatLevel = i[1:0];
      step(2);
      check(ptcClass, (i == 0) ? 16'h0 : ((i == 3) ? 16'h2 : 16'h1));
    end
    ptcModeSwitch = 1'b1;
    auxTermPin = 1'b1;
    step(HOLD + 8);
    check(thermistorFault, 1'b0);
    check(auxFuncActive, 1'b0);
    wrSel(1'b1, 4'h0, FUNC_PTC);
    heatLevel = 2'h3;
    step(HOLD - 4);
    heatLevel = 2'h2;
    step(5);
    check(thermistorFault, 1'b0);
    heatLevel = 2'h3;
    waitFlag(3, HOLD + 10, n);
    check(n > HOLD, 1'b1);
    heatLevel = 2'h0;
    ptcModeSwitch = 1'b0;
    doReset();
    step(4);
    check(auxFuncActive, 1'b1);
    wrSel(1'b1, 4'h0, FUNC_PTC);
    waitFlag(3, HOLD + 10, n);
    check(outputStop, 1'b1);
    endOfTest();
  end
endmodule
